// *** mds_status_out.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mds_consts.svh"
// How it works
// RULE1: any alarm turns fault output off, cuts motor current, shows alarm code.
// RULE2: deviation above a 0.01..300.00 rev threshold, default 20.00, raises alarm.
// RULE3: alarm initial drive setting, 0 disables, 1 enables, default disabled.
// RULE4: caution output is on while any warning is active.
// RULE5: overvoltage, deviation and enabled overload thresholds raise warnings.
// RULE6: motion-active output stays on while operation is commanded, cable or not.
// RULE7: ready only when power on, inputs idle, no alarm, motor idle, no tool.
// RULE8: host applies start inputs only after it sees ready on.
// RULE9: in-position when motion idle and position within completion range.
// RULE10: completion range 1 to 100 steps, default 1, step is 0.72 degrees.
// RULE11: origin select 0: on when idle at home, off while coordinate unset.
// RULE12: origin select 1: on while coordinate is set, regardless of position.
// RULE13: torque-clamp on when torque reaches the active limit.
// RULE14: speed-attained on while speed within band around command speed.
// RULE15: band 0 to 400 r/min, default 200, zero keeps output off.
// RULE16: 500 pulses per revolution on each quadrature channel.
// RULE17: second channel 90 degrees from first, level at first's rise gives direction.
// RULE18: one index pulse per revolution, stretched to at least 1 ms.
// RULE19: index visible only on an assigned general output terminal; the code also drives index_pulse_out and a status bit.
// RULE20: flags registered, inactive at reset, fault held off until evaluation valid.
module mds_status_out #(
	parameter int IDX_CYC = `MDS_IDX_CYC
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_ok_pin,
	input wire logic start_any_pin,
	input wire logic free_pin,
	input wire logic stop_pin,
	input wire logic servo_on_pin,
	input wire logic servo_on_assigned,
	input wire logic tool_busy_pin,
	input wire logic eval_valid,
	input wire logic core_alarm,
	input wire logic [7:0] core_alarm_code,
	input wire logic core_warning,
	input wire logic motion_cmd,
	input wire logic [14:0] pos_deviation,
	input wire logic [8:0] bus_volt,
	input wire logic [6:0] load_pct,
	input wire logic [7:0] torque,
	input wire logic [7:0] torque_limit,
	input wire mds_pkg::mds_spd_t speed,
	input wire mds_pkg::mds_spd_t cmd_speed,
	input wire mds_pkg::mds_pos_t cmd_pos,
	input wire mds_pkg::mds_pos_t act_pos,
	input wire logic coord_set,
	input wire logic quad_step,
	input wire logic quad_dir,
	output logic fault_status_out,
	output logic motor_current_en,
	output logic [7:0] alarm_code_out,
	output logic caution_out,
	output logic move_out,
	output logic ready_out,
	output logic in_pos_out,
	output logic origin_out,
	output logic torque_clamp_out,
	output logic speed_attained_out,
	output logic quad_channel_first,
	output logic quad_channel_second,
	output logic index_pulse_out,
	output logic [2:0] general_output_terminals
);
	import mds_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_meta_reg <= 6'h00;
			pin_sync_reg <= 6'h00;
		end else if (ce) begin
			pin_meta_reg <= {power_ok_pin, start_any_pin, free_pin, stop_pin, servo_on_pin, tool_busy_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	wire logic pw_ok = pin_sync_reg[5];
	wire logic st_any = pin_sync_reg[4];
	wire logic fr_in = pin_sync_reg[3];
	wire logic sp_in = pin_sync_reg[2];
	wire logic son_in = pin_sync_reg[1];
	wire logic tool_in = pin_sync_reg[0];

	// ----------------------------------------
	// apb registers
	// ----------------------------------------
	logic [5:0] ctrl_reg;
	logic [14:0] almdev_reg;
	logic [14:0] wrndev_reg;
	logic [8:0] ovolt_reg;
	logic [6:0] ovld_reg;
	logic [6:0] inpos_reg;
	logic [8:0] vaband_reg;
	logic alarm_clr;
	logic addr_ok;
	logic [31:0] rd_next;
	logic [31:0] stat_word;
	wire logic wr_en = psel & penable & pwrite & ce & addr_ok;
	always_comb begin
		addr_ok = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) && (paddr[7:0] <= `MDS_STAT_OFS);
		rd_next = 32'h00000000;
		case (paddr[7:0])
			`MDS_CTRL_OFS: rd_next = {26'h0000000, ctrl_reg};
			`MDS_ALMDEV_OFS: rd_next = {17'h00000, almdev_reg};
			`MDS_WRNDEV_OFS: rd_next = {17'h00000, wrndev_reg};
			`MDS_OVOLT_OFS: rd_next = {23'h000000, ovolt_reg};
			`MDS_OVLD_OFS: rd_next = {25'h0000000, ovld_reg};
			`MDS_INPOS_OFS: rd_next = {25'h0000000, inpos_reg};
			`MDS_VABAND_OFS: rd_next = {23'h000000, vaband_reg};
			`MDS_STAT_OFS: rd_next = stat_word;
			default: rd_next = 32'h00000000;
		endcase
	end
	// always zero wait states: the access phase completes on its first edge
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~addr_ok;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable) begin
			prdata <= rd_next;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_reg <= `MDS_CTRL_RST; // RULE3
			almdev_reg <= `MDS_ALMDEV_RST; // RULE2
			wrndev_reg <= `MDS_WRNDEV_RST;
			ovolt_reg <= `MDS_OVOLT_RST;
			ovld_reg <= `MDS_OVLD_RST; // RULE5
			inpos_reg <= `MDS_INPOS_RST; // RULE10
			vaband_reg <= `MDS_VABAND_RST; // RULE15
		end else if (wr_en) begin
			case (paddr[7:0])
				`MDS_CTRL_OFS: ctrl_reg <= pwdata[5:0];
				`MDS_ALMDEV_OFS: almdev_reg <= pwdata[14:0];
				`MDS_WRNDEV_OFS: wrndev_reg <= pwdata[14:0];
				`MDS_OVOLT_OFS: ovolt_reg <= pwdata[8:0];
				`MDS_OVLD_OFS: ovld_reg <= pwdata[6:0];
				`MDS_INPOS_OFS: inpos_reg <= pwdata[6:0];
				`MDS_VABAND_OFS: vaband_reg <= pwdata[8:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end
	assign alarm_clr = wr_en && (paddr[7:0] == `MDS_CTRL_OFS) && pwdata[`MDS_C_ACLR];
	wire logic init_drv = ctrl_reg[`MDS_C_INIT];
	wire logic pos_mode = ctrl_reg[`MDS_C_POSMODE];

	// ----------------------------------------
	// alarm and fault
	// ----------------------------------------
	mds_fault_st_t fst_reg;
	logic drive_hold_reg;
	wire logic dev_alarm = pos_deviation > almdev_reg; // RULE2
	wire logic alarm_now = core_alarm | dev_alarm;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fst_reg <= MDS_WAIT;
			alarm_code_out <= 8'h00;
		end else if (ce) begin
			case (fst_reg)
				MDS_WAIT: if (eval_valid) begin // RULE20
					fst_reg <= MDS_RUN;
				end
				MDS_RUN: if (alarm_now) begin // RULE1
					fst_reg <= MDS_FAULT;
					alarm_code_out <= core_alarm ? core_alarm_code : `MDS_ACODE_DEV;
				end
				MDS_FAULT: if (alarm_clr && !alarm_now) begin
					fst_reg <= MDS_RUN;
					alarm_code_out <= 8'h00;
				end
				default: fst_reg <= MDS_WAIT;
			endcase
		end
	end
	// without initial drive, current stays cut after a clear until motion is dropped
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_hold_reg <= 1'b1;
		end else if (ce) begin
			if (fst_reg != MDS_RUN) begin
				drive_hold_reg <= 1'b1;
			end else if (init_drv || !motion_cmd) begin // RULE3
				drive_hold_reg <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fault_status_out <= 1'b0;
			motor_current_en <= 1'b0;
		end else if (ce) begin
			fault_status_out <= (fst_reg == MDS_RUN) && !alarm_now; // RULE1 RULE20
			motor_current_en <= (fst_reg == MDS_RUN) && !alarm_now && !drive_hold_reg; // RULE1
		end
	end
	wire logic alarm_on = fst_reg != MDS_RUN;

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	logic signed [24:0] pos_err;
	logic [24:0] pos_abs;
	logic signed [13:0] spd_err;
	logic [13:0] spd_abs;
	logic warn_any;
	logic ready_next;
	always_comb begin
		pos_err = 25'(act_pos) - 25'(cmd_pos);
		pos_abs = pos_err[24] ? 25'(-pos_err) : 25'(pos_err);
		spd_err = 14'(speed) - 14'(cmd_speed);
		spd_abs = spd_err[13] ? 14'(-spd_err) : 14'(spd_err);
		warn_any = core_warning || (bus_volt > ovolt_reg) || (pos_deviation > wrndev_reg)
			|| (ctrl_reg[`MDS_C_OVLEN] && (load_pct >= ovld_reg)); // RULE5
		ready_next = pos_mode && pw_ok && !st_any && !fr_in && !sp_in
			&& (son_in || !servo_on_assigned) && !alarm_on && !motion_cmd && !tool_in; // RULE7
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			caution_out <= 1'b0;
			move_out <= 1'b0;
			ready_out <= 1'b0;
			in_pos_out <= 1'b0;
			origin_out <= 1'b0;
			torque_clamp_out <= 1'b0;
			speed_attained_out <= 1'b0;
		end else if (ce) begin
			caution_out <= warn_any; // RULE4
			move_out <= motion_cmd; // RULE6
			ready_out <= ready_next; // RULE7 RULE8
			in_pos_out <= pos_mode && !move_out && (pos_abs <= 25'(inpos_reg)); // RULE9 RULE10
			if (ctrl_reg[`MDS_C_ORGSEL]) begin
				origin_out <= pos_mode && coord_set; // RULE12
			end else begin
				origin_out <= pos_mode && coord_set && !move_out && (cmd_pos == 24'sh000000); // RULE11
			end
			torque_clamp_out <= torque >= torque_limit; // RULE13
			speed_attained_out <= (vaband_reg != 9'h000) && (spd_abs <= 14'(vaband_reg)); // RULE14 RULE15
		end
	end

	// ----------------------------------------
	// encoder outputs
	// ----------------------------------------
	logic [1:0] quad_reg;
	logic [10:0] edge_reg;
	logic [17:0] idx_cnt_reg;
	wire logic at_zero = quad_step && (quad_dir ? (edge_reg == `MDS_EDGES_REV - 11'h001) : (edge_reg == 11'h001));
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			quad_reg <= 2'h0;
			edge_reg <= 11'h000;
		end else if (ce && quad_step) begin
			// gray sequence 00,01,11,10 gives a 90 degree offset
			quad_reg <= quad_dir ? {quad_reg[0], ~quad_reg[1]} : {~quad_reg[0], quad_reg[1]}; // RULE17
			if (quad_dir) begin
				edge_reg <= (edge_reg == `MDS_EDGES_REV - 11'h001) ? 11'h000 : edge_reg + 11'h001; // RULE16
			end else begin
				edge_reg <= (edge_reg == 11'h000) ? `MDS_EDGES_REV - 11'h001 : edge_reg - 11'h001;
			end
		end
	end
	assign quad_channel_first = quad_reg[0];
	assign quad_channel_second = quad_reg[1];
	// stretch so slow receivers still catch the index
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			idx_cnt_reg <= 18'h00000;
			index_pulse_out <= 1'b0;
		end else if (ce) begin
			if (at_zero) begin
				idx_cnt_reg <= 18'(IDX_CYC - 1); // RULE18
				index_pulse_out <= 1'b1;
			end else if (idx_cnt_reg != 18'h00000) begin
				idx_cnt_reg <= idx_cnt_reg - 18'h00001;
			end else begin
				index_pulse_out <= 1'b0;
			end
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_term
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					general_output_terminals[gi] <= 1'b0;
				end else if (ce) begin
					general_output_terminals[gi] <= (ctrl_reg[`MDS_C_IDXHI:`MDS_C_IDXLO] == 2'(gi + 1))
						&& index_pulse_out; // RULE19
				end
			end
		end
	endgenerate
	always_comb begin
		stat_word = {21'h000000, fst_reg == MDS_WAIT, alarm_on, general_output_terminals != 3'h0,
			index_pulse_out, speed_attained_out, torque_clamp_out, origin_out, in_pos_out,
			ready_out, move_out, caution_out};
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence alarm_seen;
		ce && alarm_now && fst_reg == MDS_RUN;
	endsequence
	sequence step_fwd;
		ce && quad_step && quad_dir;
	endsequence
	fault_off_a: assert property (@(posedge sys_clk) disable iff (srst) alarm_seen |=> !fault_status_out && !motor_current_en && fst_reg == MDS_FAULT) else $error("fault not raised on alarm"); // RULE1
	fault_hold_a: assert property (@(posedge sys_clk) disable iff (srst) fst_reg == MDS_WAIT |=> !fault_status_out) else $error("fault on before evaluation"); // RULE20
	dev_alarm_a: assert property (@(posedge sys_clk) disable iff (srst) ce && fst_reg == MDS_RUN && pos_deviation > almdev_reg |=> fst_reg == MDS_FAULT) else $error("deviation alarm missed"); // RULE2
	caution_a: assert property (@(posedge sys_clk) disable iff (srst) ce && bus_volt > ovolt_reg |=> caution_out) else $error("caution not set"); // RULE4
	ready_block_a: assert property (@(posedge sys_clk) disable iff (srst) ce && (alarm_on || motion_cmd) |=> !ready_out) else $error("ready while busy"); // RULE7
	in_pos_a: assert property (@(posedge sys_clk) disable iff (srst) in_pos_out |-> $past(pos_abs) <= 25'($past(inpos_reg))) else $error("in position outside range"); // RULE9
	va_zero_a: assert property (@(posedge sys_clk) disable iff (srst) $past(vaband_reg) == 9'h000 |-> !speed_attained_out) else $error("speed band zero yet on"); // RULE15
	quad_phase_a: assert property (@(posedge sys_clk) disable iff (srst) step_fwd ##1 ce && !quad_step |-> $changed(quad_channel_first) != $changed(quad_channel_second)) else $error("quadrature steps not one channel at a time"); // RULE17
	idx_start_a: assert property (@(posedge sys_clk) disable iff (srst) ce && at_zero |=> index_pulse_out && idx_cnt_reg == 18'(IDX_CYC - 1)) else $error("index not started at wrap"); // RULE18
	idx_len_a: assert property (@(posedge sys_clk) disable iff (srst || !ce) $rose(index_pulse_out) |-> index_pulse_out [*8]) else $error("index pulse too short"); // RULE18
	term_a: assert property (@(posedge sys_clk) disable iff (srst) ctrl_reg[`MDS_C_IDXHI:`MDS_C_IDXLO] == 2'h0 |=> general_output_terminals == 3'h0) else $error("index on unassigned terminal"); // RULE19

	// ----------------------------------------
	// flag follow checks
	// ----------------------------------------
	// reaching the run state, from wait or by a clear from fault, is the only way the fault output can come on
	sequence wait_exit;
		ce && fst_reg == MDS_WAIT && eval_valid;
	endsequence
	sequence step_wrap;
		ce && quad_step && quad_dir && edge_reg == `MDS_EDGES_REV - 11'h001;
	endsequence
	eval_run_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE20
		wait_exit |=> fst_reg == MDS_RUN)
		else $error("evaluation valid did not start run");
	current_cut_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE1
		ce && alarm_now |=> !motor_current_en)
		else $error("current not cut on alarm");
	caution_core_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE4
		ce && core_warning |=> caution_out)
		else $error("caution missed core warning");
	move_on_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE6
		ce && motion_cmd |=> move_out)
		else $error("move output not on");
	move_off_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE6
		ce && !motion_cmd |=> !move_out)
		else $error("move output not off");
	ready_on_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
		ce && ready_next |=> ready_out)
		else $error("ready not raised");
	origin_unset_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
		ce && !coord_set |=> !origin_out)
		else $error("origin on with coordinate unset");
	origin_set_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
		ce && pos_mode && ctrl_reg[`MDS_C_ORGSEL] && coord_set |=> origin_out)
		else $error("origin off with coordinate set");
	clamp_on_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE13
		ce && torque >= torque_limit |=> torque_clamp_out)
		else $error("torque clamp not on");
	clamp_off_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE13
		ce && torque < torque_limit |=> !torque_clamp_out)
		else $error("torque clamp not off");
	speed_in_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE14
		ce && vaband_reg != 9'h000 && spd_abs <= 14'(vaband_reg) |=> speed_attained_out)
		else $error("speed attained not on in band");
	edge_wrap_a: assert property (@(posedge sys_clk) disable iff (srst) // RULE16
		step_wrap |=> edge_reg == 11'h000)
		else $error("edge count did not wrap");
	// a low enable must freeze every state, not just the outputs
	ce_freeze_a: assert property (@(posedge sys_clk) disable iff (srst)
		!ce |=> $stable(fst_reg) && $stable(edge_reg) && $stable(caution_out))
		else $error("state moved with enable low");
endmodule
`default_nettype wire

// *** mds_consts.svh ***
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH
// register byte offsets
`define MDS_CTRL_OFS 8'h00
`define MDS_ALMDEV_OFS 8'h04
`define MDS_WRNDEV_OFS 8'h08
`define MDS_OVOLT_OFS 8'h0C
`define MDS_OVLD_OFS 8'h10
`define MDS_INPOS_OFS 8'h14
`define MDS_VABAND_OFS 8'h18
`define MDS_STAT_OFS 8'h1C
// control field positions
`define MDS_C_INIT 0
`define MDS_C_OVLEN 1
`define MDS_C_POSMODE 2
`define MDS_C_ORGSEL 3
`define MDS_C_IDXLO 4
`define MDS_C_IDXHI 5
`define MDS_C_ACLR 8
// reset values (deviation in 0.01 rev, volts, percent, steps, r/min)
`define MDS_CTRL_RST 6'h04
`define MDS_ALMDEV_RST 15'h07D0
`define MDS_WRNDEV_RST 15'h07D0
`define MDS_OVOLT_RST 9'h1B3
`define MDS_OVLD_RST 7'h64
`define MDS_INPOS_RST 7'h01
`define MDS_VABAND_RST 9'h0C8
// alarm code shown for excessive deviation
`define MDS_ACODE_DEV 8'h10
// quadrature edges per motor revolution: 500 pulses x 4
`define MDS_EDGES_REV 11'h7D0
// index stretch, least time
`define MDS_CLK_NS 5
`define MDS_IDX_NS 1000000
`define MDS_IDX_CYC ((`MDS_IDX_NS + `MDS_CLK_NS - 1) / `MDS_CLK_NS)
`endif

// *** mds_pkg.sv ***
package mds_pkg;
	typedef logic signed [23:0] mds_pos_t;
	typedef logic signed [12:0] mds_spd_t;
	typedef enum logic [1:0] {
		MDS_WAIT,
		MDS_RUN,
		MDS_FAULT
	} mds_fault_st_t;
endpackage

// *** mds_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mds_host_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ready_out,
	input wire logic start_req,
	input wire logic quad_channel_first,
	input wire logic quad_channel_second,
	output logic start_any_pin,
	output logic signed [15:0] pulse_cnt
);
	logic first_d;
	// ------------------------------
	// start request, held back until ready is seen
	// ------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst || !start_req) begin
			start_any_pin <= 1'b0;
		end else if (ready_out) begin
			start_any_pin <= 1'b1;
		end
	end
	// ------------------------------
	// quadrature receiver
	// ------------------------------
	// second channel low at first rise means forward
	always_ff @(posedge sys_clk) begin
		first_d <= quad_channel_first;
		if (srst) begin
			pulse_cnt <= 16'sh0000;
		end else if (quad_channel_first && !first_d) begin
			pulse_cnt <= quad_channel_second ? pulse_cnt - 16'sh0001 : pulse_cnt + 16'sh0001;
		end
	end
endmodule
`default_nettype wire

// *** tb_mds_status_out.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mds_consts.svh"
module tb_mds_status_out;
	import mds_pkg::*;
	logic sys_clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic pready, pslverr, start_any_pin, start_req = 1'b0;
	logic power_ok_pin = 1'b1, free_pin = 1'b0, stop_pin = 1'b0, servo_on_pin = 1'b0;
	logic servo_on_assigned = 1'b0, tool_busy_pin = 1'b0, eval_valid = 1'b0;
	logic core_alarm = 1'b0, core_warning = 1'b0, motion_cmd = 1'b0, coord_set = 1'b0;
	logic quad_step = 1'b0, quad_dir = 1'b1;
	logic [7:0] core_alarm_code = 8'h2A, torque = 8'h00, torque_limit = 8'h50;
	logic [14:0] pos_deviation = 15'h07D0;
	logic [8:0] bus_volt = 9'h1B3;
	logic [6:0] load_pct = 7'h00;
	mds_spd_t speed = 13'sh0000, cmd_speed = 13'sh03E8;
	mds_pos_t cmd_pos = 24'sh000064, act_pos = 24'sh000064;
	logic fault_status_out, motor_current_en, caution_out, move_out, ready_out, in_pos_out;
	logic origin_out, torque_clamp_out, speed_attained_out, quad_channel_first, quad_channel_second;
	logic index_pulse_out, idx_prev = 1'b0;
	logic [7:0] alarm_code_out;
	logic [2:0] general_output_terminals;
	logic signed [15:0] pulse_cnt;
	int n_fail = 0, cmp_count = 0, idx_rise = 0, idx_hi = 0, term_hi = 0, term_bad = 0;

	always #2.5 sys_clk = ~sys_clk;
	mds_status_out #(.IDX_CYC(20)) i_mds_status_out (.sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_ok_pin(power_ok_pin), .start_any_pin(start_any_pin), .free_pin(free_pin),
		.stop_pin(stop_pin), .servo_on_pin(servo_on_pin), .servo_on_assigned(servo_on_assigned),
		.tool_busy_pin(tool_busy_pin), .eval_valid(eval_valid), .core_alarm(core_alarm),
		.core_alarm_code(core_alarm_code), .core_warning(core_warning), .motion_cmd(motion_cmd),
		.pos_deviation(pos_deviation), .bus_volt(bus_volt), .load_pct(load_pct), .torque(torque),
		.torque_limit(torque_limit), .speed(speed), .cmd_speed(cmd_speed), .cmd_pos(cmd_pos), .act_pos(act_pos),
		.coord_set(coord_set), .quad_step(quad_step), .quad_dir(quad_dir), .fault_status_out(fault_status_out),
		.motor_current_en(motor_current_en), .alarm_code_out(alarm_code_out), .caution_out(caution_out),
		.move_out(move_out), .ready_out(ready_out), .in_pos_out(in_pos_out), .origin_out(origin_out),
		.torque_clamp_out(torque_clamp_out), .speed_attained_out(speed_attained_out),
		.quad_channel_first(quad_channel_first), .quad_channel_second(quad_channel_second),
		.index_pulse_out(index_pulse_out), .general_output_terminals(general_output_terminals));
	mds_host_model i_mds_host_model (.sys_clk(sys_clk), .srst(srst), .ready_out(ready_out), .start_req(start_req),
		.quad_channel_first(quad_channel_first), .quad_channel_second(quad_channel_second),
		.start_any_pin(start_any_pin), .pulse_cnt(pulse_cnt));
	always @(negedge sys_clk) begin
		idx_prev <= index_pulse_out;
		if (index_pulse_out && !idx_prev) idx_rise++;
		if (index_pulse_out) idx_hi++;
		if (general_output_terminals[0]) term_hi++;
		if (general_output_terminals[2:1] != 2'h0) term_bad++;
	end
	// ------------------------------
	// shared tasks
	// ------------------------------
	task automatic test_done();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] r, output logic e);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			n_fail++;
			test_done();
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdchk(input logic [31:0] a, exp, input logic experr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk("prdata", exp, r);
		chk("pslverr", experr, e);
	endtask
	// registered flags need one cycle, synced pins three
	task automatic settle();
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic steps(input int n, input logic dir);
		repeat (n) begin
			@(posedge sys_clk);
			quad_step <= 1'b1;
			quad_dir <= dir;
			@(posedge sys_clk);
			quad_step <= 1'b0;
		end
		repeat (40) @(posedge sys_clk);
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_reset();
		chk("fault_rst", 0, fault_status_out);
		chk("current_rst", 0, motor_current_en);
		rdchk(32'h00, 32'h4, 1'b0);
		rdchk(32'h04, 32'h7D0, 1'b0);
		rdchk(32'h08, 32'h7D0, 1'b0);
		rdchk(32'h0C, 32'h1B3, 1'b0);
		rdchk(32'h10, 32'h64, 1'b0);
		rdchk(32'h14, 32'h1, 1'b0);
		rdchk(32'h18, 32'hC8, 1'b0);
		rdchk(32'h20, 32'h0, 1'b1);
		settle();
		chk("fault_wait", 0, fault_status_out);
	endtask
	task automatic t_fault();
		eval_valid <= 1'b1;
		settle();
		chk("fault_on", 1, fault_status_out);
		core_alarm <= 1'b1;
		motion_cmd <= 1'b1;
		settle();
		chk("fault_alarm", 0, fault_status_out);
		chk("current_cut", 0, motor_current_en);
		chk("alarm_code", 8'h2A, alarm_code_out);
		core_alarm <= 1'b0;
		wr(`MDS_CTRL_OFS, 32'h104);
		settle();
		chk("fault_clr", 1, fault_status_out);
		chk("no_init_drive", 0, motor_current_en);
		motion_cmd <= 1'b0;
		settle();
		chk("current_back", 1, motor_current_en);
		wr(`MDS_CTRL_OFS, 32'h5);
		motion_cmd <= 1'b1;
		pos_deviation <= 15'h07D1;
		settle();
		chk("dev_code", `MDS_ACODE_DEV, alarm_code_out);
		chk("dev_caution", 1, caution_out);
		pos_deviation <= 15'h07D0;
		wr(`MDS_CTRL_OFS, 32'h105);
		settle();
		chk("init_drive", 1, motor_current_en);
		chk("dev_edge", 1, fault_status_out);
		motion_cmd <= 1'b0;
		wr(`MDS_CTRL_OFS, 32'h4);
	endtask
	task automatic t_caution();
		settle();
		chk("caution_idle", 0, caution_out);
		bus_volt <= 9'h1B4;
		settle();
		chk("over_volt", 1, caution_out);
		bus_volt <= 9'h1B3;
		load_pct <= 7'h64;
		settle();
		chk("ovld_gated", 0, caution_out);
		wr(`MDS_CTRL_OFS, 32'h6);
		settle();
		chk("ovld_warn", 1, caution_out);
		load_pct <= 7'h00;
		core_warning <= 1'b1;
		settle();
		chk("core_warn", 1, caution_out);
		core_warning <= 1'b0;
		wr(`MDS_CTRL_OFS, 32'h4);
	endtask
	task automatic t_ready();
		settle();
		chk("ready_idle", 1, ready_out);
		start_req <= 1'b1;
		settle();
		settle();
		chk("start_pin", 1, start_any_pin);
		chk("ready_start", 0, ready_out);
		start_req <= 1'b0;
		motion_cmd <= 1'b1;
		settle();
		chk("move_on", 1, move_out);
		chk("ready_move", 0, ready_out);
		start_req <= 1'b1;
		settle();
		chk("start_held", 0, start_any_pin);
		start_req <= 1'b0;
		motion_cmd <= 1'b0;
		servo_on_assigned <= 1'b1;
		settle();
		chk("ready_servo", 0, ready_out);
		servo_on_assigned <= 1'b0;
		tool_busy_pin <= 1'b1;
		settle();
		chk("ready_tool", 0, ready_out);
		tool_busy_pin <= 1'b0;
	endtask
	task automatic t_place();
		act_pos <= 24'sh000066;
		settle();
		chk("inpos_out", 0, in_pos_out);
		wr(`MDS_INPOS_OFS, 32'h2);
		settle();
		chk("inpos_range", 1, in_pos_out);
		motion_cmd <= 1'b1;
		settle();
		chk("inpos_move", 0, in_pos_out);
		motion_cmd <= 1'b0;
		coord_set <= 1'b1;
		cmd_pos <= 24'sh000000;
		settle();
		chk("home_on", 1, origin_out);
		cmd_pos <= 24'sh000005;
		settle();
		chk("home_off", 0, origin_out);
		wr(`MDS_CTRL_OFS, 32'hC);
		settle();
		chk("coord_on", 1, origin_out);
		coord_set <= 1'b0;
		settle();
		chk("coord_off", 0, origin_out);
	endtask
	task automatic t_misc();
		ce <= 1'b0;
		torque <= 8'h50;
		settle();
		chk("ce_freeze", 0, torque_clamp_out);
		ce <= 1'b1;
		torque <= 8'h50;
		speed <= 13'sh04B0;
		settle();
		chk("tclamp_on", 1, torque_clamp_out);
		chk("speed_in", 1, speed_attained_out);
		torque <= 8'h4F;
		speed <= 13'sh04B1;
		settle();
		chk("tclamp_off", 0, torque_clamp_out);
		chk("speed_out", 0, speed_attained_out);
		speed <= 13'sh03E8;
		wr(`MDS_VABAND_OFS, 32'h0);
		settle();
		chk("band_zero", 0, speed_attained_out);
		wr(`MDS_CTRL_OFS, 32'h0);
		settle();
		chk("ready_speed_mode", 0, ready_out);
	endtask
	task automatic t_enc();
		wr(`MDS_CTRL_OFS, 32'h14);
		steps(2000, 1'b1);
		chk("pulses_rev", 16'sd500, pulse_cnt);
		chk("idx_once", 1, idx_rise);
		chk("idx_wide", 1, idx_hi >= 20);
		chk("term_copy", 1, term_hi >= 20);
		chk("term_other", 0, term_bad);
		steps(4, 1'b0);
		chk("reverse", 16'sd499, pulse_cnt);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_fault();
		t_caution();
		t_ready();
		t_place();
		t_misc();
		t_enc();
		test_done();
	end
	initial begin
		#400000;
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
